// File: shared/dtc_pkg.sv
// Shared constants and types for the dual timer control and mode block.
package dtc_pkg;

  localparam logic [7:0] DTC_ADDR_CTRL = 8'h88;
  localparam logic [7:0] DTC_ADDR_MODE = 8'h89;
  localparam logic [7:0] DTC_ADDR_T0L = 8'h8a;
  localparam logic [7:0] DTC_ADDR_T1L = 8'h8b;
  localparam logic [7:0] DTC_ADDR_T0H = 8'h8c;
  localparam logic [7:0] DTC_ADDR_T1H = 8'h8d;

  localparam logic [7:0] DTC_RESET_BYTE = 8'h00;
  localparam logic [7:0] DTC_READ_NONE = 8'h00;

  // Bit positions in the run and interrupt control register.
  localparam int DTC_B_TF1 = 7;
  localparam int DTC_B_TR1 = 6;
  localparam int DTC_B_TF0 = 5;
  localparam int DTC_B_TR0 = 4;
  localparam int DTC_B_IE1 = 3;
  localparam int DTC_B_IT1 = 2;
  localparam int DTC_B_IE0 = 1;
  localparam int DTC_B_IT0 = 0;

  // Bit positions in the mode select register.
  localparam int DTC_B_TIMER1_GATE_ENABLE = 7;
  localparam int DTC_B_CT1 = 6;
  localparam int DTC_B_M1_HI = 5;
  localparam int DTC_B_M1_LO = 4;
  localparam int DTC_B_TIMER0_GATE_ENABLE = 3;
  localparam int DTC_B_CT0 = 2;
  localparam int DTC_B_M0_HI = 1;
  localparam int DTC_B_M0_LO = 0;

  // Low byte bits that take part in the 13-bit mode.
  localparam int DTC_LO13_W = 5;
  localparam int DTC_T13_W = 13;

  // Indices into the synchronised input vector.
  localparam int DTC_SI_IRQ0 = 0;
  localparam int DTC_SI_IRQ1 = 1;
  localparam int DTC_SI_T0PIN = 2;
  localparam int DTC_SI_T1PIN = 3;
  localparam int DTC_SI_EXTCLK = 4;
  localparam int DTC_SYNC_W = 5;

  typedef enum logic [1:0] {
    DTC_MODE_13 = 2'b00,
    DTC_MODE_16 = 2'b01,
    DTC_MODE_8AR = 2'b10,
    DTC_MODE_SPLIT = 2'b11
  } dtc_mode_e;

  typedef enum logic [1:0] {
    DTC_PS_DIV12 = 2'b00,
    DTC_PS_DIV4 = 2'b01,
    DTC_PS_DIV48 = 2'b10,
    DTC_PS_EXT8 = 2'b11
  } dtc_ps_e;

  localparam int DTC_DIV_SYS12 = 12;
  localparam int DTC_DIV_SYS4 = 4;
  localparam int DTC_DIV_SYS48 = 48;
  localparam int DTC_DIV_EXT = 8;

endpackage

// File: logic/dtc_sync.sv
// Two-stage input synchroniser with edge detection on the synchronised level.
`timescale 1ns/10ps
module dtc_sync #(
  parameter int W = 5
) (
  input logic clk,
  input logic rst,
  input logic ce,
  input logic [W-1:0] din,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } dtc_sync_s;

  dtc_sync_s st;
  dtc_sync_s next_st;

  initial
  begin
    if (W < 1)
      $error("dtc_sync needs at least one input");
  end

  // The first stage feeds only the second; edges compare stages two and three.
  always_comb
  begin
    next_st = st;
    next_st.s1 = din;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      st <= '0;
    else if (ce)
      st <= next_st;
  end

  assign level = st.s2;
  assign rise = st.s2 & ~st.s3;
  assign fall = ~st.s2 & st.s3;

endmodule

// File: logic/dtc_prescale.sv
// Timer prescaler giving one-cycle ticks at a divided system clock or external clock rate.
`timescale 1ns/10ps
module dtc_prescale #(
  parameter int CNT_W = 6
) (
  input logic clk,
  input logic rst,
  input logic ce,
  input dtc_pkg::dtc_ps_e sel,
  input logic ext_rise,
  output logic tick
);
  import dtc_pkg::*;

  localparam logic [CNT_W-1:0] LAST12 = CNT_W'(DTC_DIV_SYS12 - 1);
  localparam logic [CNT_W-1:0] LAST4 = CNT_W'(DTC_DIV_SYS4 - 1);
  localparam logic [CNT_W-1:0] LAST48 = CNT_W'(DTC_DIV_SYS48 - 1);
  localparam logic [2:0] LAST_EXT = 3'(DTC_DIV_EXT - 1);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [2:0] ext_cnt;
    logic tick;
  } dtc_prescale_s;

  dtc_prescale_s st;
  dtc_prescale_s next_st;
  logic [CNT_W-1:0] last;

  initial
  begin
    if ((1 << CNT_W) < DTC_DIV_SYS48)
      $error("dtc_prescale counter too narrow for the largest divisor");
  end

  always_comb
  begin
    next_st = st;
    last = LAST12;
    next_st.tick = 1'b0;
    if (sel == DTC_PS_DIV4)
      last = LAST4;
    else if (sel == DTC_PS_DIV48)
      last = LAST48;
    // External clock is counted by its synchronised rising edges.
    if (sel == DTC_PS_EXT8)
    begin
      next_st.cnt = '0;
      if (ext_rise)
      begin
        next_st.ext_cnt = st.ext_cnt + 3'h1;
        next_st.tick = (st.ext_cnt == LAST_EXT);
      end
    end
    else if (st.cnt >= last)
    begin
      next_st.cnt = '0;
      next_st.tick = 1'b1;
    end
    else
      next_st.cnt = st.cnt + CNT_W'(1);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      st <= '0;
    else if (ce)
      st <= next_st;
  end

  assign tick = st.tick;

endmodule

// File: logic/dtc_top.sv
// Run, flag and mode control for two counter/timers and two external interrupt inputs.
`timescale 1ns/10ps
module dtc_top (
  input logic CLK,
  input logic RST,
  input logic CE,
  input logic [7:0] SFR_ADDR,
  input logic SFR_WE,
  input logic [7:0] SFR_WDATA,
  input logic SFR_BIT_WE,
  input logic [2:0] SFR_BIT_POS,
  input logic SFR_BIT_VAL,
  output logic [7:0] SFR_RDATA,
  input logic VEC_TIMER0_ACK,
  input logic VEC_TIMER1_ACK,
  input logic VEC_EXT_IRQ0_ACK,
  input logic VEC_EXT_IRQ1_ACK,
  input logic EXT_IRQ0_INPUT,
  input logic EXT_IRQ1_INPUT,
  input logic EXT_IRQ0_POLARITY,
  input logic EXT_IRQ1_POLARITY,
  input logic TIMER0_COUNT_PIN,
  input logic TIMER1_COUNT_PIN,
  input logic EXT_CLK_PIN,
  input dtc_pkg::dtc_ps_e PRESCALE_SELECT,
  input logic TIMER0_SYSCLK_SELECT,
  input logic TIMER1_SYSCLK_SELECT,
  output logic TIMER0_OVERFLOW_FLAG,
  output logic TIMER1_OVERFLOW_FLAG,
  output logic EXT_IRQ0_FLAG,
  output logic EXT_IRQ1_FLAG,
  output logic TIMER1_OVERFLOW_PULSE
);
  import dtc_pkg::*;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] mode;
    logic [7:0] t0l;
    logic [7:0] t0h;
    logic [7:0] t1l;
    logic [7:0] t1h;
    logic [7:0] rdata;
    logic t1_ovf_pulse;
  } dtc_top_s;

  dtc_top_s st;
  dtc_top_s next_st;

  logic [DTC_SYNC_W-1:0] pins;
  logic [DTC_SYNC_W-1:0] lvl;
  logic [DTC_SYNC_W-1:0] rise;
  logic [DTC_SYNC_W-1:0] fall;
  logic ps_tick;

  // One counter step: result is overflow, high byte, low byte.
  function automatic logic [16:0] step(
    input dtc_mode_e md,
    input logic [7:0] lo,
    input logic [7:0] hi
  );
    logic [DTC_T13_W-1:0] t13;
    logic [15:0] t16;
    logic ovf;
    logic [7:0] nlo;
    logic [7:0] nhi;
    t13 = {hi, lo[DTC_LO13_W-1:0]};
    t16 = {hi, lo};
    ovf = 1'b0;
    nlo = lo;
    nhi = hi;
    case (md)
      DTC_MODE_13:
      begin
        // Upper low-byte bits are left as last written.
        ovf = &t13;
        t13 = t13 + DTC_T13_W'(1);
        nlo = {lo[7:DTC_LO13_W], t13[DTC_LO13_W-1:0]};
        nhi = t13[DTC_T13_W-1:DTC_LO13_W];
      end
      DTC_MODE_16:
      begin
        ovf = &t16;
        t16 = t16 + 16'h0001;
        nlo = t16[7:0];
        nhi = t16[15:8];
      end
      DTC_MODE_8AR:
      begin
        ovf = &lo;
        nlo = ovf ? hi : lo + 8'h01;
      end
      default:
      begin
        ovf = &lo;
        nlo = lo + 8'h01;
      end
    endcase
    return {ovf, nhi, nlo};
  endfunction

  assign pins = {EXT_CLK_PIN, TIMER1_COUNT_PIN, TIMER0_COUNT_PIN,
                 EXT_IRQ1_INPUT, EXT_IRQ0_INPUT};

  dtc_sync #(
    .W(DTC_SYNC_W)
  ) u_sync (
    .clk(CLK),
    .rst(RST),
    .ce(CE),
    .din(pins),
    .level(lvl),
    .rise(rise),
    .fall(fall)
  );

  dtc_prescale #(
    .CNT_W(6)
  ) u_prescale (
    .clk(CLK),
    .rst(RST),
    .ce(CE),
    .sel(PRESCALE_SELECT),
    .ext_rise(rise[DTC_SI_EXTCLK]),
    .tick(ps_tick)
  );

  always_comb
  begin
    dtc_mode_e mode0;
    dtc_mode_e mode1;
    logic split;
    logic act0;
    logic act1;
    logic edge0;
    logic edge1;
    logic tick0;
    logic tick1;
    logic run0;
    logic run1;
    logic inc0;
    logic inc1;
    logic inc0h;
    logic ovf0;
    logic ovf1;
    logic ovf0h;
    logic set_tf0;
    logic set_tf1;
    logic set_ie0;
    logic set_ie1;
    logic [16:0] r0;
    logic [16:0] r1;
    run1 = 1'b0;
    inc1 = 1'b0;
    next_st = st;
    mode0 = dtc_mode_e'(st.mode[DTC_B_M0_HI:DTC_B_M0_LO]);
    mode1 = dtc_mode_e'(st.mode[DTC_B_M1_HI:DTC_B_M1_LO]);
    split = (mode0 == DTC_MODE_SPLIT);

    // An input is active when its synchronised level matches its polarity.
    act0 = (lvl[DTC_SI_IRQ0] == EXT_IRQ0_POLARITY);
    act1 = (lvl[DTC_SI_IRQ1] == EXT_IRQ1_POLARITY);
    edge0 = EXT_IRQ0_POLARITY ? rise[DTC_SI_IRQ0] : fall[DTC_SI_IRQ0];
    edge1 = EXT_IRQ1_POLARITY ? rise[DTC_SI_IRQ1] : fall[DTC_SI_IRQ1];
    set_ie0 = st.ctrl[DTC_B_IT0] ? edge0 : act0;
    set_ie1 = st.ctrl[DTC_B_IT1] ? edge1 : act1;

    tick0 = TIMER0_SYSCLK_SELECT | ps_tick;
    tick1 = TIMER1_SYSCLK_SELECT | ps_tick;

    // Timer0 counter, also the low counter in split mode.
    run0 = st.ctrl[DTC_B_TR0] & (~st.mode[DTC_B_TIMER0_GATE_ENABLE] | act0);
    inc0 = run0 & (st.mode[DTC_B_CT0] ? fall[DTC_SI_T0PIN] : tick0);
    r0 = step(mode0, st.t0l, st.t0h);
    ovf0 = inc0 & r0[16];
    if (inc0)
    begin
      next_st.t0l = r0[7:0];
      next_st.t0h = r0[15:8];
    end

    // In split mode the timer0 high byte is a plain timer under timer1 run.
    inc0h = split & st.ctrl[DTC_B_TR1] & tick0;
    ovf0h = inc0h & (&st.t0h);
    if (inc0h)
      next_st.t0h = st.t0h + 8'h01;

    // Timer1 loses its run bit and external pin while timer0 is split.
    if (split)
    begin
      run1 = (mode1 != DTC_MODE_SPLIT);
      inc1 = run1 & tick1;
    end
    else
    begin
      run1 = (mode1 != DTC_MODE_SPLIT) & st.ctrl[DTC_B_TR1]
             & (~st.mode[DTC_B_TIMER1_GATE_ENABLE] | act1);
      inc1 = run1 & (st.mode[DTC_B_CT1] ? fall[DTC_SI_T1PIN] : tick1);
    end
    r1 = step(mode1, st.t1l, st.t1h);
    ovf1 = inc1 & r1[16];
    if (inc1)
    begin
      next_st.t1l = r1[7:0];
      next_st.t1h = r1[15:8];
    end
    next_st.t1_ovf_pulse = ovf1;

    set_tf0 = ovf0;
    set_tf1 = split ? ovf0h : ovf1;

    // Vectoring clears first, software writes next, hardware sets last.
    if (VEC_TIMER0_ACK)
      next_st.ctrl[DTC_B_TF0] = 1'b0;
    if (VEC_TIMER1_ACK)
      next_st.ctrl[DTC_B_TF1] = 1'b0;
    if (VEC_EXT_IRQ0_ACK && st.ctrl[DTC_B_IT0])
      next_st.ctrl[DTC_B_IE0] = 1'b0;
    if (VEC_EXT_IRQ1_ACK && st.ctrl[DTC_B_IT1])
      next_st.ctrl[DTC_B_IE1] = 1'b0;

    if (SFR_WE)
    begin
      if (SFR_ADDR == DTC_ADDR_CTRL)
        next_st.ctrl = SFR_WDATA;
      else if (SFR_ADDR == DTC_ADDR_MODE)
        next_st.mode = SFR_WDATA;
      else if (SFR_ADDR == DTC_ADDR_T0L)
        next_st.t0l = SFR_WDATA;
      else if (SFR_ADDR == DTC_ADDR_T1L)
        next_st.t1l = SFR_WDATA;
      else if (SFR_ADDR == DTC_ADDR_T0H)
        next_st.t0h = SFR_WDATA;
      else if (SFR_ADDR == DTC_ADDR_T1H)
        next_st.t1h = SFR_WDATA;
    end
    if (SFR_BIT_WE && SFR_ADDR == DTC_ADDR_CTRL)
      next_st.ctrl[SFR_BIT_POS] = SFR_BIT_VAL;

    if (set_tf0)
      next_st.ctrl[DTC_B_TF0] = 1'b1;
    if (set_tf1)
      next_st.ctrl[DTC_B_TF1] = 1'b1;
    if (set_ie0)
      next_st.ctrl[DTC_B_IE0] = 1'b1;
    if (set_ie1)
      next_st.ctrl[DTC_B_IE1] = 1'b1;

    // Read data follows the address one cycle later.
    if (SFR_ADDR == DTC_ADDR_CTRL)
      next_st.rdata = st.ctrl;
    else if (SFR_ADDR == DTC_ADDR_MODE)
      next_st.rdata = st.mode;
    else if (SFR_ADDR == DTC_ADDR_T0L)
      next_st.rdata = st.t0l;
    else if (SFR_ADDR == DTC_ADDR_T1L)
      next_st.rdata = st.t1l;
    else if (SFR_ADDR == DTC_ADDR_T0H)
      next_st.rdata = st.t0h;
    else if (SFR_ADDR == DTC_ADDR_T1H)
      next_st.rdata = st.t1h;
    else
      next_st.rdata = DTC_READ_NONE;
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      st.ctrl <= DTC_RESET_BYTE;
      st.mode <= DTC_RESET_BYTE;
      st.t0l <= DTC_RESET_BYTE;
      st.t0h <= DTC_RESET_BYTE;
      st.t1l <= DTC_RESET_BYTE;
      st.t1h <= DTC_RESET_BYTE;
      st.rdata <= DTC_READ_NONE;
      st.t1_ovf_pulse <= 1'b0;
    end
    else if (CE)
      st <= next_st;
  end

  assign SFR_RDATA = st.rdata;
  assign TIMER0_OVERFLOW_FLAG = st.ctrl[DTC_B_TF0];
  assign TIMER1_OVERFLOW_FLAG = st.ctrl[DTC_B_TF1];
  assign EXT_IRQ0_FLAG = st.ctrl[DTC_B_IE0];
  assign EXT_IRQ1_FLAG = st.ctrl[DTC_B_IE1];
  assign TIMER1_OVERFLOW_PULSE = st.t1_ovf_pulse;

endmodule

// File: verif/dtc_chk.sv
// Checker of register and flag behaviour at the timer control ports.
`timescale 1ns/10ps
module dtc_chk (
  input logic CLK,
  input logic RST,
  input logic CE,
  input logic [7:0] SFR_ADDR,
  input logic SFR_WE,
  input logic [7:0] SFR_WDATA,
  input logic SFR_BIT_WE,
  input logic [2:0] SFR_BIT_POS,
  input logic SFR_BIT_VAL,
  input logic [7:0] SFR_RDATA,
  input logic TIMER0_OVERFLOW_FLAG,
  input logic TIMER1_OVERFLOW_FLAG,
  input logic EXT_IRQ0_FLAG,
  input logic EXT_IRQ1_FLAG
);
  logic [3:0] fl;
  logic bs;
  assign fl = {TIMER1_OVERFLOW_FLAG, TIMER0_OVERFLOW_FLAG, EXT_IRQ1_FLAG, EXT_IRQ0_FLAG};
  assign bs = CE && SFR_BIT_WE && SFR_ADDR == 8'h88 && SFR_BIT_VAL;
  default clocking @(posedge CLK);
  endclocking
  default disable iff (RST);
  unmapped_read_a: assert property (CE && SFR_ADDR > 8'h8d |=> SFR_RDATA == 8'h00)
    else $error("unmapped read not zero");
  flag_readback_a: assert property (CE && SFR_ADDR == 8'h88 |=>
    {SFR_RDATA[7], SFR_RDATA[5], SFR_RDATA[3], SFR_RDATA[1]} == $past(fl))
    else $error("flag readback wrong");
  mode_readback_a: assert property (CE && SFR_WE && SFR_ADDR == 8'h89 ##1
    CE && SFR_ADDR == 8'h89 && !SFR_WE |=> SFR_RDATA == $past(SFR_WDATA, 2))
    else $error("mode readback wrong");
  reset_clear_a: assert property ($fell(RST) |-> fl == 4'h0 && SFR_RDATA == 8'h00)
    else $error("state not clear after reset");
  ce_freeze_a: assert property (!CE |=> $stable(fl) && $stable(SFR_RDATA))
    else $error("state moved with clock enable low");
  bit_set_tf1_a: assert property (bs && SFR_BIT_POS == 3'h7 |=> TIMER1_OVERFLOW_FLAG)
    else $error("timer1 flag bit write lost");
  bit_set_tf0_a: assert property (bs && SFR_BIT_POS == 3'h5 |=> TIMER0_OVERFLOW_FLAG)
    else $error("timer0 flag bit write lost");
  byte_set_irq_a: assert property (CE && SFR_WE && SFR_ADDR == 8'h88 && SFR_WDATA[3] &&
    !SFR_BIT_WE |=> EXT_IRQ1_FLAG)
    else $error("irq1 flag byte write lost");
  cover property ($rose(TIMER0_OVERFLOW_FLAG));
  cover property ($rose(TIMER1_OVERFLOW_FLAG));
  cover property ($rose(EXT_IRQ0_FLAG));
endmodule

// File: verif/dtc_core_model.sv
// Core-side model that drives register accesses and vector acknowledges.
`timescale 1ns/10ps
module dtc_core_model (
  input logic clk,
  input logic [7:0] rdata,
  output logic [7:0] addr,
  output logic we,
  output logic [7:0] wdata,
  output logic bit_we,
  output logic [2:0] bit_pos,
  output logic bit_val,
  output logic [3:0] ack
);
  initial
  begin
    {addr, we, wdata, bit_we, bit_pos, bit_val, ack} = '0;
  end
  // Released data lines show the inverse so a stale value never passes for a fresh one.
  task wr(input logic [7:0] ad, input logic [7:0] dt);
    @(negedge clk);
    addr = ad;
    wdata = dt;
    we = 1'b1;
    @(negedge clk);
    we = 1'b0;
    wdata = ~dt;
  endtask
  task bw(input logic [2:0] p, input logic v);
    @(negedge clk);
    addr = 8'h88;
    bit_pos = p;
    bit_val = v;
    bit_we = 1'b1;
    @(negedge clk);
    bit_we = 1'b0;
    bit_val = ~v;
  endtask
  task rd(input logic [7:0] ad, output logic [7:0] dt);
    @(negedge clk);
    addr = ad;
    @(negedge clk);
    dt = rdata;
  endtask
  task vec(input int i);
    @(negedge clk);
    ack[i] = 1'b1;
    @(negedge clk);
    ack = 4'h0;
  endtask
endmodule

// File: verif/test_dual_timer_control_and_mode.sv
// Self-checking bench for the dual timer control and mode block.
`timescale 1ns/10ps
module test_dual_timer_control_and_mode;
  import dtc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic xclk = 1'b0;
  logic [1:0] irq = 2'h0;
  logic [1:0] pol = 2'h3;
  logic [1:0] pin = 2'h3;
  logic [1:0] ss = 2'h0;
  dtc_ps_e ps = DTC_PS_DIV48;
  dtc_ps_e psc [3] = '{DTC_PS_DIV12, DTC_PS_DIV4, DTC_PS_DIV48};
  int div [3] = '{12, 4, 48};
  logic [3:0] ack;
  logic [7:0] a, wd, rdata, d;
  logic we, bwe, bv, t0f, t1f, i0f, i1f;
  logic [2:0] bp;
  int failures = 0;
  int tests_run = 0;
  int cyc = 0;
  int n;
  int np = 0;
  logic t1p;
  always @(negedge clk)
  begin
    if (t1p === 1'b1)
      np++;
  end
  wire [3:0] fl = {t1f, t0f, i1f, i0f};
  always #25 clk = ~clk;
  always #65 xclk = ~xclk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      tally_and_finish();
    end
  end
  dtc_top dut (.CLK(clk), .RST(rst), .CE(ce), .SFR_ADDR(a), .SFR_WE(we), .SFR_WDATA(wd),
    .SFR_BIT_WE(bwe), .SFR_BIT_POS(bp), .SFR_BIT_VAL(bv), .SFR_RDATA(rdata),
    .VEC_TIMER0_ACK(ack[0]), .VEC_TIMER1_ACK(ack[1]), .VEC_EXT_IRQ0_ACK(ack[2]),
    .VEC_EXT_IRQ1_ACK(ack[3]), .EXT_IRQ0_INPUT(irq[0]), .EXT_IRQ1_INPUT(irq[1]),
    .EXT_IRQ0_POLARITY(pol[0]), .EXT_IRQ1_POLARITY(pol[1]), .TIMER0_COUNT_PIN(pin[0]),
    .TIMER1_COUNT_PIN(pin[1]), .EXT_CLK_PIN(xclk), .PRESCALE_SELECT(ps),
    .TIMER0_SYSCLK_SELECT(ss[0]), .TIMER1_SYSCLK_SELECT(ss[1]),
    .TIMER0_OVERFLOW_FLAG(t0f), .TIMER1_OVERFLOW_FLAG(t1f), .EXT_IRQ0_FLAG(i0f),
    .EXT_IRQ1_FLAG(i1f), .TIMER1_OVERFLOW_PULSE(t1p));
  dtc_core_model core (.clk(clk), .rdata(rdata), .addr(a), .we(we), .wdata(wd),
    .bit_we(bwe), .bit_pos(bp), .bit_val(bv), .ack(ack));
  task chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    tests_run++;
    if (s !== e)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task rc(input string nm, input logic [7:0] ad, input logic [7:0] e);
    core.rd(ad, d);
    chk(nm, e, d);
  endtask
  task wf(input int i);
    n = 0;
    while (fl[i] !== 1'b1 && n < 300)
    begin
      @(negedge clk);
      n++;
    end
    chk("flag", 8'h1, {7'h0, fl[i]});
  endtask
  task ld(input logic [7:0] m, input logic [7:0] lo, input logic [7:0] hi, input logic t);
    core.wr(8'h89, m);
    core.wr({7'h45, t}, lo);
    core.wr({7'h46, t}, hi);
  endtask
  task tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    rc("ctrl", 8'h88, 8'h00);
    rc("mode", 8'h89, 8'h00);
    rc("unmapped", 8'h90, 8'h00);
    core.bw(3'h7, 1'b1);
    core.bw(3'h5, 1'b1);
    rc("bit set", 8'h88, 8'ha0);
    core.wr(8'h88, 8'h08);
    rc("byte set", 8'h88, 8'h08);
    core.wr(8'h88, 8'h00);
    $display("register test done");
    for (int t = 0; t < 2; t++)
      for (int m = 0; m < 3; m++)
      begin
        ld({2'h0, m[1:0], 2'h0, m[1:0]}, (m == 0) ? 8'h1f : 8'hff,
          (m == 2) ? 8'h80 : 8'hff, t[0]);
        core.bw({1'b1, t[0], 1'b0}, 1'b1);
        wf(2 + t);
        core.bw({1'b1, t[0], 1'b0}, 1'b0);
        core.vec(t);
        chk("vector clear", 8'h0, {7'h0, fl[2 + t]});
        repeat (60) @(negedge clk);
        rc("low", {7'h45, t[0]}, {m == 2, 7'h0});
        rc("high", {7'h46, t[0]}, {m == 2, 7'h0});
      end
    chk("pulse count", 8'h3, np[7:0]);
    ld(8'h02, 8'hff, 8'hff, 1'b0);
    core.bw(3'h4, 1'b1);
    for (int k = 0; k < 3; k++)
    begin
      ps = psc[k];
      core.bw(3'h5, 1'b0);
      wf(2);
      core.bw(3'h5, 1'b0);
      wf(2);
      chk("period", div[k][7:0], n[7:0] + 8'h2);
    end
    core.bw(3'h4, 1'b0);
    core.bw(3'h5, 1'b0);
    $display("mode and prescale tests done");
    ss = 2'h3;
    for (int t = 0; t < 2; t++)
    begin
      ld(t ? 8'h50 : 8'h05, 8'h00, 8'h00, t[0]);
      core.bw({1'b1, t[0], 1'b0}, 1'b1);
      repeat (3)
      begin
        pin[t] = 1'b0;
        repeat (6) @(negedge clk);
        pin[t] = 1'b1;
        repeat (6) @(negedge clk);
      end
      rc("pin count", {7'h45, t[0]}, 8'h03);
      core.wr(8'h89, t ? 8'h90 : 8'h09);
      repeat (20) @(negedge clk);
      rc("gate shut", {7'h45, t[0]}, 8'h03);
      irq[t] = 1'b1;
      repeat (20) @(negedge clk);
      core.rd({7'h45, t[0]}, d);
      chk("gate open", 8'h1, {7'h0, d > 8'h03});
      chk("level flag", 8'h1, {7'h0, fl[t]});
      ce = 1'b0;
      repeat (4) @(negedge clk);
      ce = 1'b1;
      irq[t] = 1'b0;
      core.bw({1'b1, t[0], 1'b0}, 1'b0);
      repeat (5) @(negedge clk);
      core.bw({1'b0, t[0], 1'b1}, 1'b0);
      core.bw({1'b0, t[0], 1'b0}, 1'b1);
      irq[t] = 1'b1;
      repeat (5) @(negedge clk);
      irq[t] = 1'b0;
      repeat (5) @(negedge clk);
      chk("edge flag", 8'h1, {7'h0, fl[t]});
      core.vec(2 + t);
      chk("edge clear", 8'h0, {7'h0, fl[t]});
    end
    $display("pin and gate tests done");
    ld(8'h33, 8'h00, 8'hff, 1'b0);
    core.bw(3'h6, 1'b1);
    wf(3);
    chk("split tf0", 8'h0, {7'h0, t0f});
    core.bw(3'h6, 1'b0);
    core.vec(1);
    ld(8'h13, 8'hff, 8'hff, 1'b1);
    core.bw(3'h6, 1'b1);
    repeat (10) @(negedge clk);
    chk("split tf1", 8'h0, {7'h0, t1f});
    core.bw(3'h6, 1'b0);
    $display("split test done");
    tally_and_finish();
  end
endmodule
bind dtc_top dtc_chk u_chk (.CLK, .RST, .CE, .SFR_ADDR, .SFR_WE, .SFR_WDATA, .SFR_BIT_WE,
  .SFR_BIT_POS, .SFR_BIT_VAL, .SFR_RDATA, .TIMER0_OVERFLOW_FLAG, .TIMER1_OVERFLOW_FLAG,
  .EXT_IRQ0_FLAG, .EXT_IRQ1_FLAG);
